// file: design/ssp_pkg.sv
/*
 * Shared constants for the sensor serial port: timing figures, derived
 * cycle counts, internal register addresses and the power state type.
 * Assumes a 20 MHz core clock and an 8-bit address/data serial frame.
 */
`default_nettype none

package ssp_pkg;

	// Core clock rate
	localparam int unsigned CLK_HZ = 20_000_000;

	// Power timing figures as printed
	localparam int unsigned T_SHDN_MS = 500;
	localparam int unsigned T_REST_EN_S = 1;
	localparam int unsigned T_REST_DIS_S = 1;

	// Longest times round down to whole cycles
	localparam int unsigned SHDN_CYC_D = T_SHDN_MS * (CLK_HZ / 1000);
	localparam int unsigned REST_EN_CYC_D = T_REST_EN_S * CLK_HZ;
	localparam int unsigned REST_DIS_CYC_D = T_REST_DIS_S * CLK_HZ;
	localparam int CNT_W = 25;

	// Serial frame layout
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int REST_W = 2;
	localparam logic [3:0] BIT_ADDR_LAST = 4'h7;
	localparam logic [3:0] BIT_DATA_FIRST = 4'h8;
	localparam logic [3:0] BIT_DATA_LAST = 4'hF;
	localparam int WR_FLAG_POS = 6;

	// Internal register addresses
	localparam logic [6:0] A_IDENT = 7'h00;
	localparam logic [6:0] A_MOTION = 7'h01;
	localparam logic [6:0] A_DX_L = 7'h02;
	localparam logic [6:0] A_DX_H = 7'h03;
	localparam logic [6:0] A_DY_L = 7'h04;
	localparam logic [6:0] A_DY_H = 7'h05;
	localparam logic [6:0] A_REST_CFG = 7'h06;
	localparam logic [6:0] A_SOFT_RESET = 7'h07;
	localparam logic [6:0] A_SHUTDOWN = 7'h08;

	// Identity value, arbitrary
	localparam logic [7:0] IDENT_VAL = 8'h5A;

	// Reset values and the all-read mask
	localparam logic [3:0] RD_MASK_RST = 4'h0;
	localparam logic [3:0] RD_MASK_ALL = 4'hF;
	localparam logic [1:0] REST_RST = 2'h0;

	// Power state machine
	typedef enum logic [1:0] {
		PW_RUN = 2'b00,
		PW_DOWN = 2'b01,
		PW_LOW = 2'b10,
		PW_WAKE = 2'b11
	} ssp_pwr_t;

endpackage

`default_nettype wire

// file: design/ssp_sync.sv
/*
 * Two-stage level synchroniser, W bits wide.
 * Assumes each bit is a slowly changing level or toggle from another domain.
 */
`timescale 1ns/1ns
`default_nettype none

module ssp_sync #(
	parameter int W = 1
) (
	input wire logic clk_in, // Destination clock
	input wire logic rstn_in, // Synchronous reset, active low
	input wire logic [W-1:0] d_in, // Asynchronous level
	output logic [W-1:0] q_out // Synchronised level
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	// First stage feeds only the second
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			meta_ff <= '0;
			q_ff <= '0;
		end else begin
			meta_ff <= d_in;
			q_ff <= meta_ff;
		end
	end

	assign q_out = q_ff;

endmodule

`default_nettype wire

// file: design/ssp_top.sv
/*
 * Sensor serial port and power sequencing. Link logic runs on the host's
 * serial clock; register state, motion flag and power states on mclk_in.
 * Assumes the host keeps its documented gaps, so words held by one domain
 * are stable while the other reads them after a synchronised toggle.
 */
`timescale 1ns/1ns
`default_nettype none

module ssp_top
	import ssp_pkg::*;
#(
	parameter logic [CNT_W-1:0] SHDN_CYC = CNT_W'(SHDN_CYC_D),
	parameter logic [CNT_W-1:0] REST_EN_CYC = CNT_W'(REST_EN_CYC_D),
	parameter logic [CNT_W-1:0] REST_DIS_CYC = CNT_W'(REST_DIS_CYC_D)
) (
	input wire logic mclk_in, // Core clock
	input wire logic rstn_in, // Reset, active low
	input wire logic sclk_in, // Serial clock from host
	input wire logic port_select_n_in, // Port select, active low
	input wire logic mosi_in, // Serial data in
	output logic miso_out, // Serial data out
	output logic miso_oe_n_out, // MISO drive enable, active low
	input wire logic frame_valid_in, // New displacement from image path
	input wire logic [15:0] frame_dx_in, // X displacement
	input wire logic [15:0] frame_dy_in, // Y displacement
	output logic motion_n_out, // Motion pin, active low
	output logic low_power_out, // Low-current state reached
	output logic motion_ok_out // Motion data valid
);

	// Link domain state
	logic [3:0] lk_cnt_ff;
	logic [7:0] lk_sh_ff;
	logic lk_rd_ff;
	logic [7:0] lk_addr_ff;
	logic [7:0] lk_data_ff;
	logic lk_wr_tgl_ff;
	logic lk_rd_tgl_ff;
	logic miso_ff;
	logic [6:0] miso_tail_ff;
	wire lk_clr = port_select_n_in | ~rstn_in;
	wire lk_addr_done = (lk_cnt_ff == BIT_ADDR_LAST);
	wire lk_data_done = (lk_cnt_ff == BIT_DATA_LAST);
	wire lk_is_wr = lk_sh_ff[WR_FLAG_POS];

	// Core domain state
	logic [1:0] tgl_sync;
	logic wr_prev_ff;
	logic rd_prev_ff;
	logic [7:0] rd_data_ff;
	logic motion_ff;
	logic [3:0] rd_mask_ff;
	logic [15:0] dx_ff;
	logic [15:0] dy_ff;
	logic [1:0] rest_ff;
	logic shdn_ff;
	ssp_pwr_t pwr_st_ff;
	logic [CNT_W-1:0] pwr_cnt_ff;

	// Shift and bit count on rising clock; select high clears the port
	always_ff @(posedge sclk_in or posedge lk_clr) begin
		if (lk_clr) begin
			lk_cnt_ff <= 4'h0;
			lk_sh_ff <= 8'h00;
			lk_rd_ff <= 1'b0;
		end else begin
			lk_cnt_ff <= lk_cnt_ff + 4'h1;
			lk_sh_ff <= {lk_sh_ff[6:0], mosi_in};
			if (lk_addr_done)
				lk_rd_ff <= ~lk_is_wr;
			else if (lk_data_done)
				lk_rd_ff <= 1'b0;
		end
	end

	// Completed address and write data, held for the core to read
	always_ff @(posedge sclk_in) begin
		if (lk_addr_done)
			lk_addr_ff <= {lk_sh_ff[6:0], mosi_in};
		if (lk_data_done && lk_addr_ff[7])
			lk_data_ff <= {lk_sh_ff[6:0], mosi_in};
	end

	// Event toggles toward the core; only full reset clears them
	always_ff @(posedge sclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			lk_wr_tgl_ff <= 1'b0;
			lk_rd_tgl_ff <= 1'b0;
		end else begin
			if (lk_data_done && lk_addr_ff[7] && !port_select_n_in)
				lk_wr_tgl_ff <= ~lk_wr_tgl_ff;
			if (lk_addr_done && !lk_is_wr && !port_select_n_in)
				lk_rd_tgl_ff <= ~lk_rd_tgl_ff;
		end
	end

	// Read data shifted out MSB first after falling clock edges
	always_ff @(negedge sclk_in or posedge lk_clr) begin
		if (lk_clr) begin
			miso_ff <= 1'b0;
			miso_tail_ff <= 7'h00;
		end else if (lk_rd_ff && lk_cnt_ff == BIT_DATA_FIRST) begin
			miso_ff <= rd_data_ff[7];
			miso_tail_ff <= rd_data_ff[6:0];
		end else begin
			miso_ff <= miso_tail_ff[6];
			miso_tail_ff <= {miso_tail_ff[5:0], 1'b0};
		end
	end

	// Drive only during a read; release at once on select high
	assign miso_out = miso_ff;
	assign miso_oe_n_out = ~(lk_rd_ff & ~port_select_n_in);

	// Bring both toggles into the core domain
	ssp_sync #(
		.W(2)
	) u_tgl_sync (
		.clk_in(mclk_in),
		.rstn_in(rstn_in),
		.d_in({lk_wr_tgl_ff, lk_rd_tgl_ff}),
		.q_out(tgl_sync)
	);

	// Event decode; address word is stable once its toggle arrives
	wire wr_ev = tgl_sync[1] ^ wr_prev_ff;
	wire rd_ev = tgl_sync[0] ^ rd_prev_ff;
	wire [6:0] ev_addr = lk_addr_ff[6:0];
	wire wr_motion = wr_ev && ev_addr == A_MOTION;
	wire wr_rest = wr_ev && ev_addr == A_REST_CFG;
	wire wr_soft = wr_ev && ev_addr == A_SOFT_RESET;
	wire wr_shdn = wr_ev && ev_addr == A_SHUTDOWN;
	wire core_clr = ~rstn_in | wr_soft;
	wire frame_ok = frame_valid_in && pwr_st_ff == PW_RUN;

	// Delta reads mark the read mask
	wire [3:0] rd_hit = {4{rd_ev}} & {ev_addr == A_DY_H,
		ev_addr == A_DY_L, ev_addr == A_DX_H, ev_addr == A_DX_L};
	wire all_read = (rd_mask_ff | rd_hit) == RD_MASK_ALL;
	wire mot_clr = wr_motion | (motion_ff & all_read);
	wire nxt_motion = frame_ok | (motion_ff & ~mot_clr);
	wire [3:0] nxt_rd_mask = (frame_ok | mot_clr) ? RD_MASK_RST :
		(rd_mask_ff | rd_hit);
	wire keep_sum = motion_ff & ~mot_clr;
	wire [15:0] nxt_dx = frame_ok ? (keep_sum ? dx_ff + frame_dx_in :
		frame_dx_in) : (mot_clr ? 16'h0000 : dx_ff);
	wire [15:0] nxt_dy = frame_ok ? (keep_sum ? dy_ff + frame_dy_in :
		frame_dy_in) : (mot_clr ? 16'h0000 : dy_ff);

	// Read data selection
	wire [7:0] rd_mux =
		(ev_addr == A_IDENT) ? IDENT_VAL :
		(ev_addr == A_MOTION) ? {motion_ff, 6'h00, low_power_out} :
		(ev_addr == A_DX_L) ? dx_ff[7:0] :
		(ev_addr == A_DX_H) ? dx_ff[15:8] :
		(ev_addr == A_DY_L) ? dy_ff[7:0] :
		(ev_addr == A_DY_H) ? dy_ff[15:8] :
		(ev_addr == A_REST_CFG) ? {6'h00, rest_ff} :
		(ev_addr == A_SHUTDOWN) ? {7'h00, shdn_ff} : 8'h00;

	// Edge detectors for the synchronised toggles
	always_ff @(posedge mclk_in) begin
		if (!rstn_in) begin
			wr_prev_ff <= 1'b0;
			rd_prev_ff <= 1'b0;
		end else begin
			wr_prev_ff <= tgl_sync[1];
			rd_prev_ff <= tgl_sync[0];
		end
	end

	// Read data word, held for the link's first falling data edge
	always_ff @(posedge mclk_in) begin
		if (!rstn_in)
			rd_data_ff <= 8'h00;
		else if (rd_ev)
			rd_data_ff <= rd_mux;
	end

	// Motion flag, read mask and accumulated deltas; set wins over clear
	always_ff @(posedge mclk_in) begin
		if (core_clr) begin
			motion_ff <= 1'b0;
			rd_mask_ff <= RD_MASK_RST;
			dx_ff <= 16'h0000;
			dy_ff <= 16'h0000;
		end else begin
			motion_ff <= nxt_motion;
			rd_mask_ff <= nxt_rd_mask;
			dx_ff <= nxt_dx;
			dy_ff <= nxt_dy;
		end
	end

	assign motion_n_out = ~motion_ff;

	// Power controls; soft reset or full reset is the only way out of shutdown
	always_ff @(posedge mclk_in) begin
		if (core_clr) begin
			rest_ff <= REST_RST;
			shdn_ff <= 1'b0;
		end else begin
			if (wr_rest)
				rest_ff <= lk_data_ff[REST_W-1:0];
			if (wr_shdn)
				shdn_ff <= 1'b1;
		end
	end

	// Power sequencing decode
	wire want_low = shdn_ff | (rest_ff != REST_RST);
	wire [CNT_W-1:0] down_lim = shdn_ff ? SHDN_CYC : REST_EN_CYC;
	wire [CNT_W-1:0] cnt_inc = pwr_cnt_ff + CNT_W'(1);
	wire down_done = cnt_inc >= down_lim;
	wire wake_done = cnt_inc >= REST_DIS_CYC;
	ssp_pwr_t nxt_pwr_st;
	logic [CNT_W-1:0] nxt_pwr_cnt;

	// Power state machine
	always_comb begin
		nxt_pwr_st = pwr_st_ff;
		nxt_pwr_cnt = cnt_inc;
		unique case (pwr_st_ff)
			PW_RUN: begin
				nxt_pwr_cnt = '0;
				if (want_low)
					nxt_pwr_st = PW_DOWN;
			end
			PW_DOWN: begin
				if (!want_low) begin
					nxt_pwr_st = PW_RUN;
					nxt_pwr_cnt = '0;
				end else if (down_done) begin
					nxt_pwr_st = PW_LOW;
					nxt_pwr_cnt = '0;
				end
			end
			PW_LOW: begin
				nxt_pwr_cnt = '0;
				if (!want_low)
					nxt_pwr_st = PW_WAKE;
			end
			PW_WAKE: begin
				if (want_low) begin
					nxt_pwr_st = PW_DOWN;
					nxt_pwr_cnt = '0;
				end else if (wake_done) begin
					nxt_pwr_st = PW_RUN;
					nxt_pwr_cnt = '0;
				end
			end
		endcase
	end

	// Power state registers
	always_ff @(posedge mclk_in) begin
		if (core_clr) begin
			pwr_st_ff <= PW_RUN;
			pwr_cnt_ff <= '0;
		end else begin
			pwr_st_ff <= nxt_pwr_st;
			pwr_cnt_ff <= nxt_pwr_cnt;
		end
	end

	assign low_power_out = (pwr_st_ff == PW_LOW);
	assign motion_ok_out = (pwr_st_ff == PW_RUN);

	// Checks on the core domain
	shdn_bound_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(pwr_st_ff == PW_DOWN && shdn_ff) |-> pwr_cnt_ff < SHDN_CYC)
		else $error("shutdown settle exceeds its limit");
	rest_bound_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(pwr_st_ff == PW_DOWN && !shdn_ff) |-> pwr_cnt_ff < REST_EN_CYC)
		else $error("rest entry exceeds its limit");
	wake_bound_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		pwr_st_ff == PW_WAKE |-> pwr_cnt_ff < REST_DIS_CYC)
		else $error("rest exit exceeds its limit");
	motion_set_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(frame_ok && !wr_soft) |=> !motion_n_out)
		else $error("motion pin not low after a frame");
	motion_wclr_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		(wr_motion && !frame_valid_in) |=> motion_n_out && rd_mask_ff == 4'h0)
		else $error("motion write did not clear the pin");
	miso_release_a: assert property (@(posedge mclk_in) disable iff (!rstn_in)
		port_select_n_in |-> miso_oe_n_out && !lk_rd_ff)
		else $error("MISO driven while select is high");

	// Checks on the link domain
	addr_capture_a: assert property (@(posedge sclk_in) disable iff (lk_clr)
		lk_addr_done |=> lk_addr_ff == lk_sh_ff)
		else $error("address byte captured wrongly");
	read_flag_a: assert property (@(posedge sclk_in) disable iff (lk_clr)
		(lk_addr_done && !lk_is_wr) |=> lk_rd_ff && !miso_oe_n_out)
		else $error("read not started after read address");
	miso_order_a: assert property (@(negedge sclk_in) disable iff (lk_clr)
		(lk_rd_ff && lk_cnt_ff == BIT_DATA_FIRST) |=>
		miso_out == rd_data_ff[7] ##1 miso_out == rd_data_ff[6])
		else $error("read data not shifted MSB first");
	write_quiet_a: assert property (@(negedge sclk_in) disable iff (lk_clr)
		(lk_cnt_ff < BIT_DATA_FIRST) |-> miso_oe_n_out && !lk_rd_ff)
		else $error("MISO driven during an address byte");

	// Main scenarios
	wr_done_c: cover property (@(posedge mclk_in) wr_ev);
	delta_clr_c: cover property (@(posedge mclk_in) motion_ff && all_read);
	low_entry_c: cover property (@(posedge mclk_in) $rose(low_power_out));
	wake_c: cover property (@(posedge mclk_in) pwr_st_ff == PW_WAKE ##1
		pwr_st_ff == PW_RUN);

endmodule

`default_nettype wire

// file: tb/ssp_host_model.sv
/*
 * Host model: serial port master that drives the clock, select and MOSI.
 * Assumes the port answers on MISO with an active-low drive enable.
 */
`timescale 1ns/1ns
`default_nettype none

module ssp_host_model (
	output logic sclk_out, // Serial clock, idles high
	output logic port_select_n_out, // Port select, active low
	output logic mosi_out, // Serial data to the port
	input wire logic miso_in, // Serial data from the port
	input wire logic miso_oe_n_in // MISO drive enable, active low
);
	// Gaps counted in host clock periods, rounded up
	localparam int T_NS = 64;
	localparam int SETUP = (120 + T_NS - 1) / T_NS;
	localparam int RD_HOLD = (120 + T_NS - 1) / T_NS;
	localparam int WR_HOLD = (20000 + T_NS - 1) / T_NS;
	localparam int ADDR_GAP = (100000 + T_NS - 1) / T_NS;
	localparam int RD_GAP = (20000 + T_NS - 1) / T_NS;
	localparam int WR_GAP = (120000 + T_NS - 1) / T_NS;
	// Half a serial clock period of at least 250 ns keeps it under 2 MHz
	localparam int HALF_CYC = (250 + T_NS - 1) / T_NS;
	logic hclk = 1'b0;
	logic miso_line;

	// Released line shows the inverse so stale data never matches
	assign miso_line = miso_oe_n_in ? ~miso_in : miso_in;

	// Idle levels of the host's pins
	initial begin
		sclk_out = 1'b1;
		port_select_n_out = 1'b1;
		mosi_out = 1'b0;
	end

	// Host clock; its edges meet those of the core clock once every 800 ns
	always #(T_NS / 2) hclk = ~hclk;

	task automatic wait_t(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// Falling edge launches MOSI; MISO is taken just before the rising edge
	task automatic xfer_bit(input logic b, output logic r);
		wait_t(HALF_CYC);
		sclk_out <= 1'b0;
		mosi_out <= b;
		wait_t(HALF_CYC);
		r = miso_line;
		sclk_out <= 1'b1;
	endtask

	task automatic xfer_byte(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) xfer_bit(b[i], r[i]);
	endtask

	task automatic open_frame();
		@(posedge hclk);
		port_select_n_out <= 1'b0;
		wait_t(SETUP);
	endtask

	task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		open_frame();
		xfer_byte({1'b1, a}, r);
		xfer_byte(d, r);
		wait_t(WR_HOLD);
		port_select_n_out <= 1'b1;
		wait_t(WR_GAP - WR_HOLD);
	endtask

	task automatic read_reg(input logic [6:0] a, output logic [7:0] d,
		output logic oe_ok);
		logic [7:0] r;
		open_frame();
		xfer_byte({1'b0, a}, r);
		wait_t(ADDR_GAP);
		oe_ok = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(1'b0, d[i]);
			oe_ok &= (miso_oe_n_in === 1'b0);
		end
		wait_t(RD_HOLD);
		port_select_n_out <= 1'b1;
		wait_t(1);
		oe_ok &= (miso_oe_n_in === 1'b1);
		wait_t(RD_GAP);
	endtask

	// Partial frame cut by select, then clock noise while deselected
	task automatic abort_frame(input int n);
		logic r;
		open_frame();
		for (int i = 0; i < n; i++) xfer_bit(1'b1, r);
		@(posedge hclk);
		port_select_n_out <= 1'b1;
		for (int i = 0; i < n; i++) xfer_bit(i[0], r);
		wait_t(RD_GAP);
	endtask
endmodule

`default_nettype wire

// file: tb/tb_sensor_serial_port_timing.sv
/*
 * Self-checking bench for the sensor serial port and power sequencing.
 * Assumes short power counts of 20 cycles and the host model as master.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_sensor_serial_port_timing
	import ssp_pkg::*;
();
	typedef struct packed {
		logic wr;
		logic [6:0] a;
		logic [7:0] d;
		logic [7:0] exp;
	} ssp_row_t;
	localparam ssp_row_t ROWS [6] = '{
		'{1'b0, A_IDENT, 8'h00, IDENT_VAL},
		'{1'b0, 7'h7F, 8'h00, 8'h00},
		'{1'b0, A_MOTION, 8'h00, 8'h00},
		'{1'b1, A_IDENT, 8'hFF, IDENT_VAL},
		'{1'b1, A_DX_L, 8'h55, 8'h00},
		'{1'b0, A_SHUTDOWN, 8'h00, 8'h00}};
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic frame_valid = 1'b0;
	logic [15:0] frame_dx = 16'h0000;
	logic [15:0] frame_dy = 16'h0000;
	logic sclk, port_select_n, mosi, miso, miso_oe_n;
	logic motion_n, low_power, motion_ok;
	int bad_count = 0;
	int n_checks = 0;

	// Core clock, 20 MHz
	always #25 mclk = ~mclk;

	ssp_top #(.SHDN_CYC(CNT_W'(20)), .REST_EN_CYC(CNT_W'(20)),
		.REST_DIS_CYC(CNT_W'(20))) u_dut (
		.mclk_in(mclk), .rstn_in(rstn), .sclk_in(sclk),
		.port_select_n_in(port_select_n), .mosi_in(mosi),
		.miso_out(miso), .miso_oe_n_out(miso_oe_n),
		.frame_valid_in(frame_valid), .frame_dx_in(frame_dx),
		.frame_dy_in(frame_dy), .motion_n_out(motion_n),
		.low_power_out(low_power), .motion_ok_out(motion_ok));

	ssp_host_model u_host (
		.sclk_out(sclk), .port_select_n_out(port_select_n),
		.mosi_out(mosi), .miso_in(miso), .miso_oe_n_in(miso_oe_n));

	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		u_host.read_reg(a, d, ok);
		check(d, exp);
		check({7'h00, ok}, 8'h01);
	endtask

	task automatic frame(input logic [15:0] dx, input logic [15:0] dy);
		@(posedge mclk);
		frame_valid <= 1'b1;
		frame_dx <= dx;
		frame_dy <= dy;
		@(posedge mclk);
		frame_valid <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask

	task automatic do_reset();
		@(posedge mclk);
		rstn <= 1'b0;
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		check({4'h0, motion_n, low_power, motion_ok, miso_oe_n}, 8'h0B);
	endtask

	// Main sequence
	initial begin
		do_reset();
		for (int i = 0; i < 6; i++) begin
			if (ROWS[i].wr) u_host.write_reg(ROWS[i].a, ROWS[i].d);
			rd_chk(ROWS[i].a, ROWS[i].exp);
		end
		// Motion pin held until all four deltas are read
		frame(16'h1234, 16'hABCD);
		check({7'h00, motion_n}, 8'h00);
		rd_chk(A_MOTION, 8'h80);
		rd_chk(A_DX_L, 8'h34);
		rd_chk(A_DX_H, 8'h12);
		rd_chk(A_DY_L, 8'hCD);
		check({7'h00, motion_n}, 8'h00);
		rd_chk(A_DY_H, 8'hAB);
		check({7'h00, motion_n}, 8'h01);
		frame(16'h0001, 16'h0000);
		u_host.write_reg(A_MOTION, 8'h00);
		check({7'h00, motion_n}, 8'h01);
		// Cut frame and deselected noise leave the port intact
		u_host.abort_frame(12);
		rd_chk(A_IDENT, IDENT_VAL);
		check({7'h00, motion_n}, 8'h01);
		// Forced rest entry, frames ignored, then wake
		u_host.write_reg(A_REST_CFG, 8'h03);
		check({6'h00, low_power, motion_ok}, 8'h02);
		frame(16'h0005, 16'h0005);
		check({7'h00, motion_n}, 8'h01);
		rd_chk(A_REST_CFG, 8'h03);
		rd_chk(A_MOTION, 8'h01);
		u_host.write_reg(A_REST_CFG, 8'h00);
		check({6'h00, low_power, motion_ok}, 8'h01);
		// Reset in mid-run with motion pending
		frame(16'h0001, 16'h0001);
		check({7'h00, motion_n}, 8'h00);
		do_reset();
		// Shutdown, then soft reset; motion data is valid again after it
		u_host.write_reg(A_SHUTDOWN, 8'h01);
		check({6'h00, low_power, motion_ok}, 8'h02);
		u_host.write_reg(A_SOFT_RESET, 8'h00);
		check({6'h00, low_power, motion_ok}, 8'h01);
		rd_chk(A_SHUTDOWN, 8'h00);
		wrap_up();
	end

	// Watchdog at one and a half times the expected run of about 3 ms
	initial begin
		#4_500_000;
		bad_count++;
		wrap_up();
	end
endmodule

`default_nettype wire
